/* File: tw8_waveform_ctrl.sv */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - Nonzero output-mode field A hands pin A to compare output A, except 01 in PWM without mode bit 2.
// - Nonzero output-mode field B hands pin B to compare output B.
// - A pin is driven only while its port direction bit says output.
// - Non-PWM, field A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clear on match set at TOP; 11 reverse; 01 toggles if bit2.
// - Phase PWM A: 10 clear up-match, set down-match; 11 reverse; 01 as fast.
// - PWM A: match ignored when compare equals TOP and field bit1 set; TOP action stays.
// - Non-PWM, field B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B: 10 clear on match set at TOP; 11 reverse; 01 reserved.
// - Phase PWM B: 10 clear up-match, set down-match; 11 reverse; 01 reserved.
// - PWM B: match ignored when compare equals TOP and field bit1 set; TOP action stays.
// - Control A bits 3 and 2 always read zero.
// - Mode is bit2 plus control A bits 1:0; 4 and 6 reserved.
// - TOP is compare A in 2,5,7, else 0xff; compare load immediate or at TOP.
// - Overflow at MAX in 0,2,3; at BOTTOM in 1,5; at TOP in 7.
// - Control B: force bits write-only, 5:4 read zero, bit3 mode, 2:0 clock.
// - Force bit in non-PWM strobes a match: no flag, no clear, reads zero.
// - Clock select: stop, /1, /8, /64, /256, /1024, pin falling, pin rising.
module tw8_waveform_ctrl (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [tw8_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Counter and compare values from the timer core.
    input wire logic [7:0] counter_in,
    input wire logic count_down_in,
    input wire logic [7:0] cmp_value_a_in,
    input wire logic [7:0] cmp_value_b_in,
    // Port logic and external clock pin.
    input wire logic port_dir_a_in,
    input wire logic port_dir_b_in,
    input wire logic port_data_a_in,
    input wire logic port_data_b_in,
    input wire logic ext_clk_pin_in,
    // Pins and timer control.
    output tw8_pkg::tw8_pin_t pin_a_out,
    output tw8_pkg::tw8_pin_t pin_b_out,
    output logic [7:0] top_out,
    output logic tick_out,
    output logic cmp_load_out,
    output logic irq_out
);
    import tw8_pkg::*;

    tw8_ctrl_a_t timer_control_a;
    tw8_ctrl_b_t timer_control_b;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [PRE_W-1:0] prescale;
    logic ext_pin_q;
    logic cmp_out_a;
    logic cmp_out_b;

    // Bus decode: the access phase is the one cycle after setup, pready rising with it.
    wire logic [7:0] reg_idx = paddr_in[tw8_pkg::ADDR_W-1:2];
    wire logic hit_a = (reg_idx == IDX_CTRL_A);
    wire logic hit_b = (reg_idx == IDX_CTRL_B);
    wire logic hit_st = (reg_idx == IDX_IRQ_STATUS);
    wire logic hit_mk = (reg_idx == IDX_IRQ_MASK);
    wire logic mapped = (hit_a | hit_b | hit_st | hit_mk) && (paddr_in[1:0] == 2'h0);
    wire logic setup = psel_in && !penable_in;
    wire logic commit = psel_in && penable_in && pready_out;
    wire logic wr_ok = commit && pwrite_in && !pslverr_out;
    wire logic wr_a = wr_ok && hit_a;
    wire logic wr_b = wr_ok && hit_b;
    wire logic wr_st = wr_ok && hit_st;
    wire logic wr_mk = wr_ok && hit_mk;

    // Reserved control A bits and write-only force bits never reach the read path.
    wire logic [7:0] rd_a = 8'(timer_control_a) & CTRL_A_RW_MASK;
    wire logic [7:0] rd_b = 8'(timer_control_b) & CTRL_B_RW_MASK;
    wire logic [31:0] next_prdata = hit_a ? {24'h000000, rd_a} :
                                    hit_b ? {24'h000000, rd_b} :
                                    hit_st ? {29'h00000000, irq_status} :
                                    hit_mk ? {29'h00000000, irq_mask} : 32'h00000000;

    // Mode assembly and classification.
    wire logic [2:0] wave_mode_sel = {timer_control_b.wave_mode_bit2,
                                      timer_control_a.wave_mode_low};
    tw8_kind_t kind;
    always_comb begin
        unique case (wave_mode_sel)
            MODE_NORMAL, MODE_CLEAR_ON_MATCH: kind = KIND_NON_PWM;
            MODE_PHASE_FF, MODE_PHASE_CMP: kind = KIND_PHASE;
            MODE_FAST_FF, MODE_FAST_CMP: kind = KIND_FAST;
            default: kind = KIND_RSVD;
        endcase
    end
    wire logic is_pwm = (kind == KIND_FAST) || (kind == KIND_PHASE);
    wire logic top_is_cmp = (wave_mode_sel == MODE_CLEAR_ON_MATCH) ||
                            (wave_mode_sel == MODE_PHASE_CMP) ||
                            (wave_mode_sel == MODE_FAST_CMP);
    wire logic [7:0] next_top = top_is_cmp ? cmp_value_a_in : CNT_MAX;

    // Prescaler taps; the free-running divider keeps running while stopped.
    wire logic ext_fall = ext_pin_q && !ext_clk_pin_in;
    wire logic ext_rise = !ext_pin_q && ext_clk_pin_in;
    logic next_tick;
    always_comb begin
        unique case (timer_control_b.clk_sel)
            CS_STOP: next_tick = 1'b0;
            CS_DIV1: next_tick = 1'b1;
            CS_DIV8: next_tick = (prescale & PRE_MASK_8) == PRE_MASK_8;
            CS_DIV64: next_tick = (prescale & PRE_MASK_64) == PRE_MASK_64;
            CS_DIV256: next_tick = (prescale & PRE_MASK_256) == PRE_MASK_256;
            CS_DIV1024: next_tick = (prescale & PRE_MASK_1024) == PRE_MASK_1024;
            CS_EXT_FALL: next_tick = ext_fall;
            CS_EXT_RISE: next_tick = ext_rise;
        endcase
    end

    // Counter events, qualified by the timer clock enable that the core also sees.
    wire logic at_top = tick_out && (counter_in == top_out);
    wire logic at_max = tick_out && (counter_in == CNT_MAX);
    wire logic at_bottom = tick_out && count_down_in && (counter_in == CNT_BOTTOM);
    wire logic match_a = tick_out && (counter_in == cmp_value_a_in);
    wire logic match_b = tick_out && (counter_in == cmp_value_b_in);
    // Reserved modes overflow as normal mode does.
    wire logic ovf_evt = (kind == KIND_PHASE) ? at_bottom :
                         (wave_mode_sel == MODE_FAST_CMP) ? at_top : at_max;

    // Forced matches only act in non-PWM modes and touch no flag.
    wire logic force_a = wr_b && pwdata_in[CTRL_B_FORCE_A_BIT] &&
                         (kind == KIND_NON_PWM);
    wire logic force_b = wr_b && pwdata_in[CTRL_B_FORCE_B_BIT] &&
                         (kind == KIND_NON_PWM);

    // In PWM a compare sitting on TOP with field bit1 set loses its match.
    wire logic ign_a = is_pwm && (cmp_value_a_in == top_out) &&
                       timer_control_a.out_mode_a[1];
    wire logic ign_b = is_pwm && (cmp_value_b_in == top_out) &&
                       timer_control_a.out_mode_b[1];

    // Next compare-output level for one channel.
    function automatic logic oc_next(input logic cur, input logic [1:0] om, input tw8_kind_t k,
                                     input logic hit, input logic ign, input logic top,
                                     input logic down, input logic tgl_ok);
        logic v;
        v = cur;
        unique case (k)
            KIND_NON_PWM: begin
                if (hit) begin
                    unique case (om)
                        OM_OFF: v = cur;
                        OM_TOGGLE: v = !cur;
                        OM_CLEAR: v = 1'b0;
                        OM_SET: v = 1'b1;
                    endcase
                end
            end
            KIND_FAST, KIND_PHASE: begin
                // The TOP action comes first; in phase mode it only stands for an ignored match.
                if (top && om[1] && (k == KIND_FAST || ign)) begin
                    v = (om == OM_CLEAR);
                end
                if (hit && !ign) begin
                    if (om == OM_TOGGLE) begin
                        v = tgl_ok ? !cur : cur;
                    end else if (om[1]) begin
                        v = (k == KIND_PHASE && down) ? (om == OM_CLEAR) : (om == OM_SET);
                    end
                end
            end
            default: v = cur;
        endcase
        return v;
    endfunction

    wire logic next_oc_a = oc_next(cmp_out_a, timer_control_a.out_mode_a, kind,
                                   match_a || force_a, ign_a, at_top, count_down_in,
                                   timer_control_b.wave_mode_bit2);
    wire logic next_oc_b = oc_next(cmp_out_b, timer_control_a.out_mode_b, kind,
                                   match_b || force_b, ign_b, at_top, count_down_in,
                                   1'b0);

    // Pin multiplexing: the direction bit always decides whether anything drives.
    // In PWM, field A value 01 without mode bit 2 leaves the pin to the port.
    wire logic a_released = is_pwm && (timer_control_a.out_mode_a == OM_TOGGLE) &&
                            !timer_control_b.wave_mode_bit2;
    wire logic own_a = (timer_control_a.out_mode_a != OM_OFF) && !a_released;
    wire logic own_b = (timer_control_a.out_mode_b != OM_OFF);
    wire tw8_pin_t next_pin_a = '{drive: own_a ? next_oc_a : port_data_a_in,
                                  oe: port_dir_a_in};
    wire tw8_pin_t next_pin_b = '{drive: own_b ? next_oc_b : port_data_b_in,
                                  oe: port_dir_b_in};

    // Compare buffers load every cycle in immediate modes and only at TOP in PWM.
    wire logic next_cmp_load = is_pwm ? at_top : 1'b1;

    // Sticky flags: a new event wins over a write-one clear in the same cycle.
    wire logic [IRQ_W-1:0] events = {match_b, match_a, ovf_evt};
    wire logic [IRQ_W-1:0] clr = wr_st ? pwdata_in[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] next_status = (irq_status & ~clr) | events;
    wire logic next_irq = |(next_status & (wr_mk ? pwdata_in[IRQ_W-1:0] : irq_mask));

    // Bus answer: data and ready are set up in the setup cycle so they leave flops.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup && !mapped;
            prdata_out <= (setup && mapped && !pwrite_in) ? next_prdata : 32'h00000000;
        end
    end

    // Control registers; force bits are strobes and are never stored.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            timer_control_a <= tw8_ctrl_a_t'(CTRL_A_RESET);
            timer_control_b <= tw8_ctrl_b_t'(CTRL_B_RESET);
        end else begin
            if (wr_a) begin
                timer_control_a <= tw8_ctrl_a_t'(pwdata_in[7:0] & CTRL_A_RW_MASK);
            end
            if (wr_b) begin
                timer_control_b <= tw8_ctrl_b_t'(pwdata_in[7:0] & CTRL_B_RW_MASK);
            end
        end
    end

    // Interrupt status and mask.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq_out <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_mk) begin
                irq_mask <= pwdata_in[IRQ_W-1:0];
            end
            irq_out <= next_irq;
        end
    end

    // Prescaler and external pin history.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prescale <= '0;
            ext_pin_q <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            ext_pin_q <= ext_clk_pin_in;
            tick_out <= next_tick;
        end
    end

    // Compare outputs, pins and timer steering.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cmp_out_a <= 1'b0;
            cmp_out_b <= 1'b0;
            pin_a_out <= '0;
            pin_b_out <= '0;
            top_out <= CNT_MAX;
            cmp_load_out <= 1'b0;
        end else begin
            cmp_out_a <= next_oc_a;
            cmp_out_b <= next_oc_b;
            pin_a_out <= next_pin_a;
            pin_b_out <= next_pin_b;
            top_out <= next_top;
            cmp_load_out <= next_cmp_load;
        end
    end

endmodule : tw8_waveform_ctrl

/* File: tw8_pkg.sv */
package tw8_pkg;

    // Bus geometry and register indices; the byte address is four times the index.
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_CTRL_A = 8'h24;
    localparam logic [7:0] IDX_CTRL_B = 8'h25;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

    // Reset values and writable bit masks of the two control registers.
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_RW_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_RW_MASK = 8'h0f;
    localparam int CTRL_B_FORCE_A_BIT = 7;
    localparam int CTRL_B_FORCE_B_BIT = 6;

    // Interrupt status and mask share one layout.
    localparam int IRQ_W = 3;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_MATCH_A_BIT = 1;
    localparam int IRQ_MATCH_B_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // Counter landmarks.
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // Waveform mode codes.
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PHASE_FF = 3'h1;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_RSVD_4 = 3'h4;
    localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
    localparam logic [2:0] MODE_RSVD_6 = 3'h6;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;

    // Output-mode field codes.
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    // Clock select codes and prescaler tap masks.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
    localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03f;
    localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3ff;

    typedef struct packed {
        logic [1:0] out_mode_a;
        logic [1:0] out_mode_b;
        logic [1:0] rsvd;
        logic [1:0] wave_mode_low;
    } tw8_ctrl_a_t;

    typedef struct packed {
        logic force_cmp_a;
        logic force_cmp_b;
        logic [1:0] rsvd;
        logic wave_mode_bit2;
        logic [2:0] clk_sel;
    } tw8_ctrl_b_t;

    // One pin: level to drive and output enable.
    typedef struct packed {
        logic drive;
        logic oe;
    } tw8_pin_t;

    typedef enum logic [1:0] {
        KIND_NON_PWM,
        KIND_FAST,
        KIND_PHASE,
        KIND_RSVD
    } tw8_kind_t;

endpackage : tw8_pkg

/* File: tw8_waveform_ctrl_checker.sv */
`timescale 1ns/1ps
module tw8_waveform_ctrl_checker (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Register bus.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [tw8_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Timer side and pins.
    input wire logic [7:0] cmp_value_a_in,
    input wire logic port_dir_a_in,
    input wire logic port_dir_b_in,
    input wire logic port_data_a_in,
    input wire logic port_data_b_in,
    input wire tw8_pkg::tw8_pin_t pin_a_out,
    input wire tw8_pkg::tw8_pin_t pin_b_out,
    input wire logic [7:0] top_out,
    input wire logic tick_out,
    input wire logic cmp_load_out
);
    import tw8_pkg::*;
    // Shadows follow committed writes, so no internal state has to be peeked at.
    logic [7:0] sh_a;
    logic [7:0] sh_b;
    wire logic commit = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
    wire logic rd_ok = psel_in && penable_in && pready_out && !pwrite_in;
    wire logic [2:0] mode = {sh_b[3], sh_a[1:0]};
    wire logic top_cmp = mode == MODE_CLEAR_ON_MATCH || mode[0] && mode[2];
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sh_a <= CTRL_A_RESET;
            sh_b <= CTRL_B_RESET;
        end else if (commit && paddr_in == {IDX_CTRL_A, 2'h0}) begin
            sh_a <= pwdata_in[7:0] & CTRL_A_RW_MASK;
        end else if (commit && paddr_in == {IDX_CTRL_B, 2'h0}) begin
            sh_b <= pwdata_in[7:0] & CTRL_B_RW_MASK;
        end
    end
    // Every property uses the single clock and the synchronous reset.
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    pin_enable_lag_a: assert property (
        !$past(rst_in) |-> pin_a_out.oe == $past(port_dir_a_in))
        else $error("pin a enable does not follow direction");
    pin_enable_lag_b_a: assert property (
        !$past(rst_in) |-> pin_b_out.oe == $past(port_dir_b_in))
        else $error("pin b enable does not follow direction");
    port_pass_a_a: assert property (
        sh_a[7:6] == OM_OFF |=> pin_a_out.drive == $past(port_data_a_in))
        else $error("pin a not port data");
    port_pass_b_a: assert property (
        sh_a[5:4] == OM_OFF |=> pin_b_out.drive == $past(port_data_b_in))
        else $error("pin b not port data");
    ready_after_setup_a: assert property (pready_out |-> $past(psel_in && !penable_in))
        else $error("ready without setup");
    ctrl_a_read_a: assert property (
        rd_ok && paddr_in == {IDX_CTRL_A, 2'h0} |-> prdata_out == {24'h0, sh_a})
        else $error("control a read value");
    ctrl_b_read_a: assert property (
        rd_ok && paddr_in == {IDX_CTRL_B, 2'h0} |-> prdata_out == {24'h0, sh_b})
        else $error("control b read value");
    top_source_a: assert property (
        !rst_in |=> top_out == ($past(top_cmp) ? $past(cmp_value_a_in) : CNT_MAX))
        else $error("top value");
    load_immediate_a: assert property (!mode[0] |=> cmp_load_out)
        else $error("compare load not immediate");
    tick_undivided_a: assert property (sh_b[2:0] == CS_DIV1 |=> tick_out)
        else $error("no tick at undivided rate");
    tick_stopped_a: assert property (sh_b[2:0] == CS_STOP |=> !tick_out)
        else $error("tick while stopped");
endmodule : tw8_waveform_ctrl_checker

/* File: tw8_waveform_ctrl_bench.sv */
`timescale 1ns/1ps
module tw8_waveform_ctrl_bench;
    import tw8_pkg::*;
    localparam logic [9:0] AD_A = {IDX_CTRL_A, 2'h0};
    localparam logic [9:0] AD_B = {IDX_CTRL_B, 2'h0};
    localparam logic [9:0] AD_ST = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0] AD_MK = {IDX_IRQ_MASK, 2'h0};
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic down = 1'b0, dir_a = 1'b0, dir_b = 1'b0, dat_a = 1'b0, dat_b = 1'b0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] counter = 8'h10, cmp_a = 8'h0, cmp_b = 8'h0, top, val;
    logic pready, pslverr, tick, cmp_load, irq, err, ea;
    tw8_pin_t pin_a, pin_b;
    int fail_count = 0;
    int num_checks = 0;
    int seed;
    tw8_waveform_ctrl i_tw8_waveform_ctrl (.ref_clk_in(ref_clk), .rst_in(rst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .counter_in(counter), .count_down_in(down), .cmp_value_a_in(cmp_a),
        .cmp_value_b_in(cmp_b), .port_dir_a_in(dir_a), .port_dir_b_in(dir_b),
        .port_data_a_in(dat_a), .port_data_b_in(dat_b), .ext_clk_pin_in(1'b0),
        .pin_a_out(pin_a), .pin_b_out(pin_b), .top_out(top), .tick_out(tick),
        .cmp_load_out(cmp_load), .irq_out(irq));
    // Clock generator.
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic pins(input logic exp_a, input logic exp_b);
        chk("pin a drive", {31'h0, exp_a}, {31'h0, pin_a.drive});
        chk("pin b drive", {31'h0, exp_b}, {31'h0, pin_b.drive});
    endtask : pins
    // One bus transfer; the wait has no bound of its own, the watchdog cuts a hang.
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Ready, read data and error are all taken at the edge that completes the transfer.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic rdchk(input string what, input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk
    // Present one counter value for a single tick, with fresh pin stimulus.
    task automatic hit(input logic [7:0] c);
        @(posedge ref_clk);
        counter <= c;
        dir_a <= 1'($urandom);
        dir_b <= 1'($urandom);
        dat_a <= 1'($urandom);
        dat_b <= 1'($urandom);
        @(posedge ref_clk);
        counter <= 8'h10;
        #1;
    endtask : hit
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_chk
    function automatic logic om_act(input logic [1:0] c, input logic o);
        return (c == OM_TOGGLE) ? ~o : (c == OM_SET) ? 1'b1 : (c == OM_CLEAR) ? 1'b0 : o;
    endfunction : om_act
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog, far beyond the few hundred cycles the tests take.
    initial begin
        #160000;
        fail_count++;
        report_and_stop;
    end
    // Main sequence.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        seed = $urandom(10076);
        rdchk("ctrl a reset", AD_A, 32'h0);
        rdchk("ctrl b reset", AD_B, 32'h0);
        repeat (8) begin
            val = 8'($urandom);
            apb(1'b1, AD_A, {24'h0, val});
            rdchk("ctrl a", AD_A, {24'h0, val & 8'hf3});
            apb(1'b1, AD_B, {24'h0, val & 8'h3f});
            rdchk("ctrl b", AD_B, {24'h0, val & 8'h0f});
        end
        apb(1'b0, 10'h3fc, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, AD_A, 32'h0);
        apb(1'b1, AD_A + 10'h1, 32'hff);
        chk("misaligned err", 32'h1, {31'h0, err});
        rdchk("ctrl a kept", AD_A, 32'h0);
        $display("test registers done");
        val = 8'($urandom_range(250, 32));
        // Compare values and direction only change on a rising edge, like every input.
        @(posedge ref_clk);
        cmp_a <= val;
        cmp_b <= val;
        ea = 1'b0;
        for (int m = 0; m < 5; m += 2) begin
            apb(1'b1, AD_B, {28'h0, 1'(m >> 2), 3'h1});
            for (int c = 3; c > 0; c--) begin
                apb(1'b1, AD_A, {24'h0, 2'(c), 2'(c), 2'h0, 2'(m)});
                hit(val);
                ea = (m == 4) ? ea : om_act(2'(c), ea);
                pins(ea, ea);
            end
        end
        apb(1'b1, AD_B, 32'h01);
        apb(1'b1, AD_A, 32'h50);
        apb(1'b1, AD_ST, 32'h7);
        apb(1'b1, AD_B, 32'hc1);
        pins(~ea, ~ea);
        rdchk("ctrl b force", AD_B, 32'h01);
        rdchk("status after force", AD_ST, 32'h0);
        $display("test non_pwm done");
        for (int c = 2; c < 4; c++) begin
            apb(1'b1, AD_A, {24'h0, 2'(c), 2'(c), 4'h3});
            hit(val);
            pins(c == 3, c == 3);
            hit(CNT_MAX);
            pins(c == 2, c == 2);
        end
        @(posedge ref_clk);
        cmp_a <= CNT_MAX;
        cmp_b <= CNT_MAX;
        apb(1'b1, AD_A, 32'ha3);
        hit(CNT_MAX);
        pins(1'b1, 1'b1);
        @(posedge ref_clk);
        cmp_a <= val;
        cmp_b <= val;
        apb(1'b1, AD_B, 32'h09);
        apb(1'b1, AD_A, 32'h53);
        apb(1'b1, AD_ST, 32'h7);
        hit(val);
        pins(1'b0, 1'b1);
        rdchk("status top", AD_ST, 32'h7);
        apb(1'b1, AD_B, 32'h01);
        hit(val);
        chk("pin a released", {31'h0, dat_a}, {31'h0, pin_a.drive});
        apb(1'b1, AD_A, 32'ha1);
        hit(val);
        pins(1'b0, 1'b0);
        @(posedge ref_clk);
        down <= 1'b1;
        hit(val);
        pins(1'b1, 1'b1);
        apb(1'b1, AD_ST, 32'h7);
        hit(CNT_BOTTOM);
        @(posedge ref_clk);
        down <= 1'b0;
        rdchk("status bottom", AD_ST, 32'h1);
        $display("test pwm done");
        apb(1'b1, AD_A, 32'h0);
        apb(1'b1, AD_ST, 32'h7);
        apb(1'b1, AD_MK, 32'h1);
        hit(CNT_MAX);
        irq_chk(1'b1);
        rdchk("status max", AD_ST, 32'h1);
        apb(1'b1, AD_MK, 32'h0);
        irq_chk(1'b0);
        apb(1'b1, AD_MK, 32'h1);
        irq_chk(1'b1);
        apb(1'b1, AD_ST, 32'h1);
        irq_chk(1'b0);
        $display("test interrupt done");
        report_and_stop;
    end
endmodule : tw8_waveform_ctrl_bench
bind tw8_waveform_ctrl tw8_waveform_ctrl_checker i_tw8_waveform_ctrl_checker (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cmp_value_a_in(cmp_value_a_in), .port_dir_a_in(port_dir_a_in),
    .port_dir_b_in(port_dir_b_in),
    .port_data_a_in(port_data_a_in), .port_data_b_in(port_data_b_in),
    .pin_a_out(pin_a_out), .pin_b_out(pin_b_out), .top_out(top_out),
    .tick_out(tick_out), .cmp_load_out(cmp_load_out));
